// ==== hdl/spm_pkg.sv ====
// Package for the switch-port MII/RMII interface block.
// Assumes one 25 MHz system clock and an APB master for the control registers.
package spm_pkg;

  // Port indices: the third and the fourth switch port
  localparam int NPORT = 2;
  localparam int THIRD = 0;
  localparam int FOURTH = 1;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h001;
  localparam logic [ADDR_W-1:0] IDX_REFCLK = 12'h057;

  // Control register fields
  localparam int CTRL_MAC_LSB = 0;
  localparam int CTRL_HALF_LSB = 2;
  localparam int CTRL_SLOW_LSB = 4;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam int REFCLK_DIS_BIT = 3;

  // Status register fields
  localparam int ST_RMII_LSB = 0;
  localparam int ST_NORMAL_BIT = 2;
  localparam int ST_READY_BIT = 3;
  localparam int ST_COL_LSB = 4;
  localparam int ST_CRS_LSB = 6;

  // Timing
  localparam int CLK_MHZ = 25;
  localparam int REF_MHZ = 50;
  localparam int REF_HALF_CYC = (CLK_MHZ * 2 / REF_MHZ) < 1 ? 1 : (CLK_MHZ * 2 / REF_MHZ);
  localparam logic [3:0] SLOW_REPEAT = 4'hA;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Widths of the nibble and the dibit
  localparam int MII_W = 4;
  localparam int RMII_W = 2;
  localparam int SYNC_W = 9;

  // Pins into one port
  typedef struct packed {
    logic tx_clock_pin_i;
    logic rx_clock_pin_i;
    logic tx_enable_in;
    logic [MII_W-1:0] tx_data_in;
    logic collision_i;
    logic carrier_sense_i;
  } spm_pin_in_t;

  // Pins out of one port
  typedef struct packed {
    logic rx_clock_pin_o;
    logic rx_clock_pin_oe;
    logic tx_clock_pin_o;
    logic tx_clock_pin_oe;
    logic rx_valid_out;
    logic [MII_W-1:0] rx_data_out;
    logic collision_o;
    logic collision_oe;
    logic carrier_sense_o;
    logic carrier_sense_oe;
  } spm_pin_out_t;

  // Fabric side of one port
  typedef struct packed {
    logic eg_ready;
    logic in_valid;
    logic [MII_W-1:0] in_data;
    logic in_carrier;
  } spm_fab_out_t;

endpackage : spm_pkg

// ==== hdl/spm_port_iface.sv ====
// Switch-port MII/RMII pin logic for the third and fourth MAC, with APB registers.
// Assumes clk at 25 MHz; all pin inputs are asynchronous and pass two flip-flops;
// the fabric side runs on clk; two-way pins are split into input, output and enable.
//
// Function
// - MII moves four bits per link clock, no line coding.
// - Half-duplex MII drives collision while transmitting and receiving together.
// - No receive-error or transmit-error signal exists on either mode.
// - RMII runs at 10 and 100 megabit per second.
// - All RMII transfers time from one shared 50 MHz reference; the internal divider gives clk/2, 12.5 MHz.
// - Internal mode drives reference on receive-clock pin, looped back externally.
// - External mode accepts reference only on fourth port transmit-clock pin.
// - RMII transmit and receive use separate two-bit paths.
// - Fourth-port strap low selects RMII after reset, else MII.
// - Third-port strap low selects RMII after reset, else MII.
// - RMII PHY mode drives carrier/valid and receive bits, takes transmit pins.
// - RMII MAC mode crosses pins toward an external PHY.
// - Fourth port sources reference from receive-clock pin, looped to transmit-clock.
// - Clock-source strap low selects normal mode with external reference.
// - Normal mode takes the whole clock source from fourth transmit-clock pin; receive-clock pins and MII PHY timing still use the internal divider.
// - Third port sources reference, never accepts external one in normal mode; the code times its RMII transfers from the fourth transmit-clock pin there.
// - Clock-source strap defaults high: clock mode from crystal.
// - Clock mode outputs reference on every RMII receive-clock pin.
// - A register bit disables the fourth port reference output.
// - Transmit side carries valid; receive side marks valid error-free data.
// - MII MAC mode crosses pins toward an external PHY.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
module spm_port_iface
  import spm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps, sampled after reset release
  input wire logic fourth_port_iface_strap,
  input wire logic third_port_iface_strap,
  input wire logic clock_source_strap,
  // Pins
  input wire spm_pin_in_t [NPORT-1:0] pin_in,
  output spm_pin_out_t [NPORT-1:0] pin_out,
  // Fabric side
  input wire logic [NPORT-1:0] eg_valid,
  input wire logic [NPORT-1:0][MII_W-1:0] eg_data,
  output spm_fab_out_t [NPORT-1:0] fab_out
);

  // Per-port state
  typedef struct packed {
    spm_pin_in_t s1; // Pin synchroniser, stage one
    spm_pin_in_t s2; // Stage two, the only stage logic reads
    logic tx_clk_q;
    logic rx_clk_q;
    logic [3:0] samp_cnt;
    logic [3:0] drv_cnt;
    spm_pin_out_t po;
    spm_fab_out_t fo;
  } spm_port_st_t;

  // Whole module state
  typedef struct packed {
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [1:0] strap_wait;
    logic straps_ready;
    logic [NPORT-1:0] rmii_sel;
    logic normal_mode;
    logic [CTRL_W-1:0] ctrl;
    logic refclk_dis;
    logic [7:0] div_cnt;
    logic ref_clk;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    spm_port_st_t [NPORT-1:0] port;
  } spm_state_t;

  spm_state_t st_r;
  spm_state_t st_nxt;

  // Decode helpers
  logic [ADDR_W-1:0] reg_idx;
  logic addr_ok;
  assign reg_idx = {2'h0, paddr[ADDR_W-1:2]};
  assign addr_ok = (paddr[1:0] == 2'h0) &&
                   (reg_idx == IDX_CTRL || reg_idx == IDX_STATUS || reg_idx == IDX_REFCLK);

  // Next-state logic for everything
  always_comb
  begin
    logic div_tog;
    logic div_rise;
    logic div_fall;
    logic rmii;
    logic mac;
    logic half;
    logic slow;
    logic mii_phy;
    logic txp_rise;
    logic rxp_fall;
    logic ref_rise;
    logic ref_fall;
    logic samp_edge;
    logic drv_edge;
    logic samp;
    logic drv;
    logic tx_en_s;
    logic [MII_W-1:0] txd_s;
    logic [DATA_W-1:0] rd;
    div_tog = 1'b0;
    div_rise = 1'b0;
    div_fall = 1'b0;
    rmii = 1'b0;
    mac = 1'b0;
    half = 1'b0;
    slow = 1'b0;
    mii_phy = 1'b0;
    txp_rise = 1'b0;
    rxp_fall = 1'b0;
    ref_rise = 1'b0;
    ref_fall = 1'b0;
    samp_edge = 1'b0;
    drv_edge = 1'b0;
    samp = 1'b0;
    drv = 1'b0;
    tx_en_s = 1'b0;
    txd_s = '0;
    rd = '0;
    st_nxt = st_r;

    // Strap capture: two flip-flops, then latch once after reset
    st_nxt.strap_s1 = {clock_source_strap, fourth_port_iface_strap, third_port_iface_strap};
    st_nxt.strap_s2 = st_r.strap_s1;
    if (!st_r.straps_ready)
    begin
      if (st_r.strap_wait != 2'h0)
      begin
        st_nxt.strap_wait = st_r.strap_wait - 2'h1;
      end
      else
      begin
        st_nxt.straps_ready = 1'b1;
        st_nxt.rmii_sel[THIRD] = ~st_r.strap_s2[0];
        st_nxt.rmii_sel[FOURTH] = ~st_r.strap_s2[1];
        // clock-source strap low means normal mode
        st_nxt.normal_mode = ~st_r.strap_s2[2];
      end
    end

    // Reference divider standing in for the crystal-derived clock
    div_tog = (st_r.div_cnt == 8'(REF_HALF_CYC - 1));
    st_nxt.div_cnt = div_tog ? 8'h00 : st_r.div_cnt + 8'h01;
    st_nxt.ref_clk = div_tog ? ~st_r.ref_clk : st_r.ref_clk;
    div_rise = div_tog & ~st_r.ref_clk;
    div_fall = div_tog & st_r.ref_clk;

    // APB: ready one cycle after setup, so every access takes two cycles
    st_nxt.pready = psel & ~penable & ~st_r.pready;
    if (psel && !penable)
    begin
      st_nxt.pslverr = ~addr_ok;
      rd = '0;
      if (reg_idx == IDX_CTRL)
      begin
        rd[CTRL_W-1:0] = st_r.ctrl;
      end
      else if (reg_idx == IDX_REFCLK)
      begin
        rd[REFCLK_DIS_BIT] = st_r.refclk_dis;
      end
      else if (reg_idx == IDX_STATUS)
      begin
        rd[ST_RMII_LSB +: NPORT] = st_r.rmii_sel;
        rd[ST_NORMAL_BIT] = st_r.normal_mode;
        rd[ST_READY_BIT] = st_r.straps_ready;
        for (int p = 0; p < NPORT; p++)
        begin
          rd[ST_COL_LSB + p] = st_r.port[p].s2.collision_i;
          rd[ST_CRS_LSB + p] = st_r.port[p].s2.carrier_sense_i;
        end
      end
      st_nxt.prdata = addr_ok ? rd : '0;
    end
    if (psel && penable && st_r.pready && pwrite && addr_ok)
    begin
      if (reg_idx == IDX_CTRL)
      begin
        st_nxt.ctrl = pwdata[CTRL_W-1:0];
      end
      if (reg_idx == IDX_REFCLK)
      begin
        st_nxt.refclk_dis = pwdata[REFCLK_DIS_BIT];
      end
    end

    // Per-port pin logic
    for (int p = 0; p < NPORT; p++)
    begin
      rmii = st_r.rmii_sel[p];
      mac = st_r.ctrl[CTRL_MAC_LSB + p];
      half = st_r.ctrl[CTRL_HALF_LSB + p];
      slow = st_r.ctrl[CTRL_SLOW_LSB + p];
      mii_phy = ~rmii & ~mac;

      // Input synchronisers; only stage two is read below
      st_nxt.port[p].s1 = pin_in[p];
      st_nxt.port[p].s2 = st_r.port[p].s1;
      st_nxt.port[p].tx_clk_q = st_r.port[p].s2.tx_clock_pin_i;
      st_nxt.port[p].rx_clk_q = st_r.port[p].s2.rx_clock_pin_i;
      tx_en_s = st_r.port[p].s2.tx_enable_in;
      txd_s = st_r.port[p].s2.tx_data_in;
      txp_rise = st_r.port[p].s2.tx_clock_pin_i & ~st_r.port[p].tx_clk_q;
      rxp_fall = ~st_r.port[p].s2.rx_clock_pin_i & st_r.port[p].rx_clk_q;

      // in normal mode both ports time RMII transfers from the fourth pin
      if (p == THIRD && st_r.normal_mode)
      begin
        ref_rise = st_r.port[FOURTH].s2.tx_clock_pin_i & ~st_r.port[FOURTH].tx_clk_q;
        ref_fall = ~st_r.port[FOURTH].s2.tx_clock_pin_i & st_r.port[FOURTH].tx_clk_q;
      end
      else
      begin
        ref_rise = txp_rise;
        ref_fall = ~st_r.port[p].s2.tx_clock_pin_i & st_r.port[p].tx_clk_q;
      end

      // MII MAC mode samples on the transmit-clock pin rise, drives on the receive-clock pin fall
      samp_edge = mii_phy ? div_rise : (rmii ? ref_rise : txp_rise);
      drv_edge = mii_phy ? div_fall : (rmii ? ref_fall : rxp_fall);

      // at 10 Mbit/s each dibit stands for ten reference cycles
      samp = samp_edge;
      drv = drv_edge;
      if (rmii && slow)
      begin
        samp = samp_edge && (st_r.port[p].samp_cnt == 4'h0);
        drv = drv_edge && (st_r.port[p].drv_cnt == 4'h0);
        if (samp_edge)
        begin
          st_nxt.port[p].samp_cnt = (st_r.port[p].samp_cnt == SLOW_REPEAT - 4'h1) ?
                                    4'h0 : st_r.port[p].samp_cnt + 4'h1;
        end
        if (drv_edge)
        begin
          st_nxt.port[p].drv_cnt = (st_r.port[p].drv_cnt == SLOW_REPEAT - 4'h1) ?
                                   4'h0 : st_r.port[p].drv_cnt + 4'h1;
        end
      end
      else
      begin
        st_nxt.port[p].samp_cnt = 4'h0;
        st_nxt.port[p].drv_cnt = 4'h0;
      end

      // inbound nibble or dibit from the transmit-side pins
      st_nxt.port[p].fo.in_valid = samp & tx_en_s;
      if (samp)
      begin
        st_nxt.port[p].fo.in_carrier = tx_en_s;
        st_nxt.port[p].fo.in_data = rmii ? {2'h0, txd_s[RMII_W-1:0]} : txd_s;
      end

      // no error bit travels either way; the pin structs carry none
      // valid only with real egress data; no error path exists
      st_nxt.port[p].fo.eg_ready = drv & eg_valid[p];
      if (drv)
      begin
        st_nxt.port[p].po.rx_valid_out = eg_valid[p];
        st_nxt.port[p].po.rx_data_out = !eg_valid[p] ? '0 :
                                        (rmii ? {2'h0, eg_data[p][RMII_W-1:0]} : eg_data[p]);
      end

      // collision and carrier driven only in MII PHY mode
      st_nxt.port[p].po.collision_oe = mii_phy;
      st_nxt.port[p].po.carrier_sense_oe = mii_phy;
      st_nxt.port[p].po.collision_o = mii_phy & half & st_r.port[p].po.rx_valid_out & tx_en_s;
      st_nxt.port[p].po.carrier_sense_o = mii_phy & (st_r.port[p].po.rx_valid_out | tx_en_s);

      // reference out of the receive-clock pin
      st_nxt.port[p].po.rx_clock_pin_oe = rmii | ~mac;
      st_nxt.port[p].po.rx_clock_pin_o =
        (p == FOURTH && st_r.refclk_dis && rmii) ? 1'b0 : st_nxt.ref_clk;
      // MII PHY mode drives the transmit clock; otherwise the pin is an input
      st_nxt.port[p].po.tx_clock_pin_oe = mii_phy;
      st_nxt.port[p].po.tx_clock_pin_o = mii_phy & st_nxt.ref_clk;
    end
  end

  // One register for the whole state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.strap_wait <= STRAP_WAIT;
      st_r.ctrl <= CTRL_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign pin_out = {st_r.port[FOURTH].po, st_r.port[THIRD].po};
  assign fab_out = {st_r.port[FOURTH].fo, st_r.port[THIRD].fo};

  // Checks on the logic above
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fourth_strap_rmii: assert property ($rose(st_r.straps_ready) |->
    st_r.rmii_sel[FOURTH] == ~$past(st_r.strap_s2[1])) else $error("fourth mode wrong");
  a_third_strap_rmii: assert property ($rose(st_r.straps_ready) |->
    st_r.rmii_sel[THIRD] == ~$past(st_r.strap_s2[0])) else $error("third mode wrong");
  a_normal_mode_latch: assert property ($rose(st_r.straps_ready) |->
    st_r.normal_mode == ~$past(st_r.strap_s2[2])) else $error("clock mode wrong");
  a_refclk_disable_low: assert property (st_r.refclk_dis && st_r.rmii_sel[FOURTH] &&
    $stable(st_r.refclk_dis) |-> !pin_out[FOURTH].rx_clock_pin_o) else $error("refclk on");
  a_collision_needs_half: assert property (pin_out[THIRD].collision_o |->
    $past(st_r.ctrl[CTRL_HALF_LSB + THIRD])) else $error("collision in full duplex");
  a_valid_pairs_ready: assert property (fab_out[THIRD].eg_ready |->
    pin_out[THIRD].rx_valid_out) else $error("ready without valid");
  // egress dibit keeps the upper lanes clear
  a_rmii_dibit_only: assert property (st_r.rmii_sel[FOURTH] && $stable(st_r.rmii_sel)
    |=> pin_out[FOURTH].rx_data_out[3:2] == 2'h0) else $error("rmii upper bits");
  a_clock_mode_drive: assert property (st_r.rmii_sel[THIRD] |-> ##1
    pin_out[THIRD].rx_clock_pin_oe) else $error("refclk not driven");
  a_mac_no_col_drive: assert property (st_r.ctrl[CTRL_MAC_LSB + FOURTH] ##1
    $stable(st_r.ctrl) |-> !pin_out[FOURTH].collision_oe) else $error("col driven in mac");
  // register access answers in two cycles
  a_apb_two_cycle: assert property (psel && !penable && !pready |=> pready)
    else $error("apb late");
  // ingress dibit keeps the upper lanes clear
  a_ingress_dibit_only: assert property (fab_out[FOURTH].in_valid &&
    $past(st_r.rmii_sel[FOURTH]) |-> fab_out[FOURTH].in_data[3:2] == 2'h0)
    else $error("rmii upper ingress bits");
  // RMII transmit clock pin stays an input
  a_rmii_txclk_input: assert property (st_r.rmii_sel[FOURTH] |=>
    !pin_out[FOURTH].tx_clock_pin_oe) else $error("rmii tx clock driven");
  // MII MAC mode takes both clocks as inputs
  a_mac_clocks_input: assert property (st_r.ctrl[CTRL_MAC_LSB + THIRD] &&
    !st_r.rmii_sel[THIRD] |=> !pin_out[THIRD].rx_clock_pin_oe &&
    !pin_out[THIRD].tx_clock_pin_oe) else $error("mac clock pins driven");
  // egress ready pulses for one cycle
  a_eg_ready_pulse: assert property (fab_out[THIRD].eg_ready |=>
    !fab_out[THIRD].eg_ready) else $error("eg ready stuck");

  c_rmii_fourth: cover property ($rose(st_r.rmii_sel[FOURTH]));
  c_normal_mode: cover property ($rose(st_r.normal_mode));
  c_egress_nibble: cover property (fab_out[THIRD].eg_ready);
  c_collision: cover property (pin_out[THIRD].collision_o);
  c_slow_ingress: cover property (st_r.ctrl[CTRL_SLOW_LSB + FOURTH] && fab_out[FOURTH].in_valid);

endmodule : spm_port_iface

// ==== testbench/spm_link_peer.sv ====
// Link peer: an external MAC or PHY on one switch port, behavioural.
// Assumes the bench loads txq and reads rxq by hierarchical reference.
`timescale 1ns/1ps
module spm_link_peer #(
  parameter int HALF_NS = 160,
  parameter int PHASE_NS = 7
)
(
  output logic link_clk,
  output logic tx_en,
  output logic [3:0] tx_dat,
  input wire logic rx_valid,
  input wire logic [3:0] rx_dat,
  input wire logic [3:0] hold_cnt
);
  logic [3:0] txq[$];
  logic [3:0] rxq[$];
  int hold_n;

  initial
  begin
    link_clk = 1'b0;
    tx_en = 1'b0;
    tx_dat = 4'h0;
    hold_n = 0;
    #PHASE_NS;
    forever #HALF_NS link_clk = ~link_clk;
  end

  // No error line ever raised; slow rate holds each unit
  always @(negedge link_clk)
  begin
    if (hold_n > 1)
      hold_n--;
    else if (txq.size() > 0)
    begin
      tx_en <= 1'b1;
      tx_dat <= txq.pop_front();
      hold_n = hold_cnt;
    end
    else
    begin
      tx_en <= 1'b0;
      tx_dat <= ~tx_dat; // Idle lines wander so stale data never passes
    end
  end

  // Receive units taken on the rising edge
  always @(posedge link_clk)
    if (rx_valid === 1'b1)
      rxq.push_back(rx_dat);
endmodule : spm_link_peer

// ==== testbench/tb.sv ====
// Bench for the switch-port pin logic: APB registers, strap capture, link traffic.
// Assumes one link peer per port; two-way pins resolved here from the enables.
`timescale 1ns/1ps
module tb
  import spm_pkg::*;
;
  logic clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic strap4;
  logic strap3;
  logic strapc;
  wire spm_pin_in_t [NPORT-1:0] pin_in;
  spm_pin_out_t [NPORT-1:0] pin_out;
  logic [NPORT-1:0] eg_valid;
  logic [NPORT-1:0][MII_W-1:0] eg_data;
  spm_fab_out_t [NPORT-1:0] fab_out;
  wire [NPORT-1:0] lclk;
  wire [NPORT-1:0] ten;
  wire [NPORT-1:0][3:0] tdat;
  wire rc4 = pin_out[FOURTH].rx_clock_pin_o & pin_out[FOURTH].rx_clock_pin_oe;
  logic [3:0] hold4;
  logic [3:0] inq[NPORT][$];
  logic [31:0] rd;
  logic err;
  int n_fail;
  int n_compared;
  int cycles;
  int tog;

  // 25 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  spm_port_iface u_spm_port_iface (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fourth_port_iface_strap(strap4), .third_port_iface_strap(strap3),
    .clock_source_strap(strapc), .pin_in(pin_in), .pin_out(pin_out),
    .eg_valid(eg_valid), .eg_data(eg_data), .fab_out(fab_out)
  );
  spm_link_peer #(.PHASE_NS(7)) u_peer3 (
    .link_clk(lclk[THIRD]), .tx_en(ten[THIRD]), .tx_dat(tdat[THIRD]), .hold_cnt(4'h1),
    .rx_valid(pin_out[THIRD].rx_valid_out), .rx_dat(pin_out[THIRD].rx_data_out)
  );
  spm_link_peer #(.PHASE_NS(53)) u_peer4 (
    .link_clk(lclk[FOURTH]), .tx_en(ten[FOURTH]), .tx_dat(tdat[FOURTH]), .hold_cnt(hold4),
    .rx_valid(pin_out[FOURTH].rx_valid_out), .rx_dat(pin_out[FOURTH].rx_data_out)
  );

  // Wire levels from every driver; undriven sense pins rest low
  for (genvar p = 0; p < NPORT; p++)
  begin : g_pin
    assign pin_in[p] = {pin_out[p].tx_clock_pin_oe ? pin_out[p].tx_clock_pin_o : lclk[p],
      pin_out[p].rx_clock_pin_oe ? pin_out[p].rx_clock_pin_o : lclk[p], ten[p], tdat[p],
      pin_out[p].collision_oe & pin_out[p].collision_o,
      pin_out[p].carrier_sense_oe & pin_out[p].carrier_sense_o};
  end

  // Ingress units as the fabric sees them
  always @(posedge clk)
    for (int p = 0; p < NPORT; p++)
      if (fab_out[p].in_valid === 1'b1)
        inq[p].push_back(fab_out[p].in_data);

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready, never assumes a count
  task apb(input logic wr, input logic [ADDR_W-1:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[ADDR_W-3:0], 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the hang guard ends this wait
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task reset_dut(input logic f4, input logic f3, input logic fc);
    int n;
    rst <= 1'b1;
    strap4 <= f4;
    strap3 <= f3;
    strapc <= fc;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    do
    begin
      apb(1'b0, IDX_STATUS, 32'h0);
      n++;
    end
    while (rd[ST_READY_BIT] !== 1'b1 && n < 20);
  endtask : reset_dut

  // Two edges let the register and then the pin settle
  task count_tog();
    logic last;
    repeat (2) @(posedge clk);
    tog = 0;
    last = rc4;
    repeat (40)
    begin
      @(posedge clk);
      if (rc4 !== last)
        tog++;
      last = rc4;
    end
  endtask : count_tog

  function automatic int peer_n(input int p);
    return (p == THIRD) ? u_peer3.rxq.size() : u_peer4.rxq.size();
  endfunction : peer_n

  function automatic logic [3:0] peer_at(input int p, input int i);
    return (p == THIRD) ? u_peer3.rxq[i] : u_peer4.rxq[i];
  endfunction : peer_at

  // Eight units each way; mask keeps the lanes the mode carries
  task traffic(input int p, input logic [3:0] mask, input logic egress);
    logic [3:0] pat[$];
    int n;
    pat = '{4'h5, 4'hA, 4'h3, 4'hC, 4'hF, 4'h0, 4'h9, 4'h6};
    inq[p].delete();
    u_peer3.rxq.delete();
    u_peer4.rxq.delete();
    foreach (pat[i])
      if (p == THIRD) u_peer3.txq.push_back(pat[i]);
      else u_peer4.txq.push_back(pat[i]);
    // Egress only when asked, so no signal is assigned twice in one step
    if (egress)
      foreach (pat[i])
      begin
        eg_valid[p] <= 1'b1;
        eg_data[p] <= pat[i];
        n = 0;
        do @(posedge clk) n++; while (fab_out[p].eg_ready !== 1'b1 && n < 400);
      end
    eg_valid[p] <= 1'b0;
    n = 0;
    while ((inq[p].size() < 8 || (egress && peer_n(p) < 8)) && n < 3000) @(posedge clk) n++;
    foreach (pat[i])
    begin
      chk({28'h0, inq[p][i]}, {28'h0, pat[i] & mask});
      if (egress)
        chk({28'h0, peer_at(p, i)}, {28'h0, pat[i] & mask});
    end
    chk(inq[p].size(), 32'h8);
  endtask : traffic

  // Main sequence
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    strap4 = 1'b0;
    strap3 = 1'b1;
    strapc = 1'b0;
    eg_valid = '0;
    eg_data = '0;
    hold4 = 4'h1;
    reset_dut(1'b0, 1'b1, 1'b0);
    chk(rd & 32'h0000000F, 32'h0000000E);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b1, IDX_CTRL, 32'hFFFFFFFF);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk(rd, 32'h0000003F);
    apb(1'b1, 12'h002, 32'h00000001);
    chk({31'h0, err}, 32'h00000001);
    apb(1'b0, 12'h002, 32'h0);
    chk({rd[30:0], err}, 32'h00000001);
    apb(1'b1, IDX_REFCLK, 32'hFFFFFFFF);
    apb(1'b0, IDX_REFCLK, 32'h0);
    chk(rd, 32'h00000008);
    count_tog();
    chk(tog, 32'h0);
    apb(1'b1, IDX_REFCLK, 32'h0);
    count_tog();
    chk({31'h0, tog > 0}, 32'h00000001);
    apb(1'b1, IDX_CTRL, 32'h00000001);
    traffic(THIRD, 4'hF, 1'b1);
    traffic(FOURTH, 4'h3, 1'b1);
    apb(1'b1, IDX_CTRL, 32'h00000023);
    hold4 <= 4'hA;
    traffic(FOURTH, 4'h3, 1'b0);
    hold4 <= 4'h1;
    reset_dut(1'b1, 1'b0, 1'b1);
    chk(rd & 32'h0000000F, 32'h00000009);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk(rd, 32'h00000000);
    print_verdict();
  end
endmodule : tb
